// ==== glasses_model.sv ====
// far side model: light sensor of the shutter glasses behind the driver
`timescale 1ns/1ps
`default_nettype none
module glasses_model
(
  input wire logic clock,
  input wire logic rst,
  input wire logic led_on,
  input wire logic [2:0] led_color,
  output logic [7:0] pulse_count,
  output logic [23:0] width_seen
);
  logic [23:0] run_reg;
  // the sensor times each lit span; a span without colour never lights
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      run_reg <= 24'h000000;
      pulse_count <= 8'h00;
      width_seen <= 24'h000000;
    end
    else if (led_on && led_color != 3'h0)
      run_reg <= run_reg + 24'h000001;
    else if (run_reg != 24'h000000)
    begin
      width_seen <= run_reg;
      pulse_count <= pulse_count + 8'h01;
      run_reg <= 24'h000000;
    end
  end
endmodule
`default_nettype wire

// ==== stereo_shutter_sync.sv ====
// stereo glasses sync: IR toggle, light pulse request and eye indicator
`timescale 1ns/1ps
`default_nettype none
module stereo_shutter_sync
(
  input wire logic clock,
  input wire logic rst,
  input wire logic stereo_en,
  input wire logic light_mode,
  input wire logic double_rate,
  input wire logic [1:0] color_sel,
  input wire logic [23:0] base_cfg,
  input wire logic [23:0] delta_cfg,
  input wire logic [23:0] width_cfg,
  input wire logic vsync,
  input wire logic subframe_end,
  input wire logic left_next,
  output logic eye_select,
  output logic ir_sync,
  output logic led_on,
  output logic [2:0] led_color
);

  localparam int unsigned CW = stereo_sync_pkg::CW;

  // ****************************************************************
  // settings, clamped into their legal windows
  // ****************************************************************

  function automatic logic [CW-1:0] clamp(input logic [CW-1:0] v,
    input logic [CW-1:0] lo, input logic [CW-1:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  wire logic [CW-1:0] base_c;
  wire logic [CW-1:0] delta_c;
  wire logic [CW-1:0] width_c;
  wire logic [CW-1:0] alt_c;
  wire logic active;
  // software may write anything; the hardware never leaves the windows
  assign base_c = clamp(base_cfg, stereo_sync_pkg::BASE_MIN_CYC,
    CW'(24'h3FFFFF)); // RL11
  assign delta_c = clamp(delta_cfg, stereo_sync_pkg::DELTA_MIN_CYC,
    stereo_sync_pkg::DELTA_MAX_CYC); // RL11
  assign width_c = clamp(width_cfg, stereo_sync_pkg::WIDTH_MIN_CYC,
    stereo_sync_pkg::WIDTH_MAX_CYC); // RL10
  assign alt_c = base_c + delta_c; // RL12
  assign active = stereo_en && double_rate; // RL13

  // ****************************************************************
  // eye indicator, led one millisecond ahead of vsync
  // ****************************************************************

  logic [CW-1:0] frame_len_reg;
  logic [CW-1:0] frame_cnt_reg;
  logic [CW-1:0] frame_cnt_next;
  logic eye_reg;
  logic ir_reg;
  wire logic lead_hit;
  wire logic [CW-1:0] lead_point;

  // frame length is learnt from the previous vsync interval
  assign frame_cnt_next = vsync ? CW'(0) : frame_cnt_reg + CW'(1); // RL14
  // limitation: a frame shorter than the lead has no point one lead
  // ahead of its end, so the change then lands just after vsync
  assign lead_point = (frame_len_reg > stereo_sync_pkg::LEAD_CYC) ?
    frame_len_reg - stereo_sync_pkg::LEAD_CYC : CW'(0);
  assign lead_hit = active && !vsync && (frame_len_reg != CW'(0)) &&
    (frame_cnt_reg == lead_point); // RL8

  // eye and IR change together at the lead point
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      frame_len_reg <= CW'(0);
      frame_cnt_reg <= CW'(0);
      eye_reg <= 1'b1;
      ir_reg <= 1'b0;
    end
    else
    begin
      if (vsync)
        frame_len_reg <= frame_cnt_reg + CW'(1);
      frame_cnt_reg <= frame_cnt_next;
      if (lead_hit)
      begin
        eye_reg <= left_next; // RL7
        ir_reg <= !ir_reg; // RL2
      end
    end
  end

  assign eye_select = eye_reg; // RL7
  // IR transmitter fires on each edge; held low in light mode
  assign ir_sync = ir_reg && !light_mode; // RL2 RL1

  // ****************************************************************
  // light pulse sequencer: offset B or B+D from subframe end
  // ****************************************************************

  stereo_sync_pkg::pulse_state_t st_reg;
  stereo_sync_pkg::pulse_state_t st_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic alt_reg;
  logic fired_reg;
  logic led_reg;
  logic [2:0] color_reg;
  wire logic [CW-1:0] offset;
  wire logic light_go;

  assign offset = alt_reg ? alt_c : base_c; // RL9
  // one pulse per frame: a second subframe end is ignored
  assign light_go = active && light_mode && subframe_end && !fired_reg; // RL3

  // sequencer next state
  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      stereo_sync_pkg::ST_IDLE:
      begin
        if (light_go)
        begin
          st_next = stereo_sync_pkg::ST_WAIT;
          cnt_next = offset;
        end
      end
      stereo_sync_pkg::ST_WAIT:
      begin
        if (cnt_reg <= CW'(1))
        begin
          st_next = stereo_sync_pkg::ST_PULSE; // RL4
          cnt_next = width_c;
        end
        else
          cnt_next = cnt_reg - CW'(1);
      end
      stereo_sync_pkg::ST_PULSE:
      begin
        if (cnt_reg <= CW'(1))
          st_next = stereo_sync_pkg::ST_IDLE;
        else
          cnt_next = cnt_reg - CW'(1);
      end
      default:
        st_next = stereo_sync_pkg::ST_IDLE;
    endcase
    if (!active || !light_mode)
      st_next = stereo_sync_pkg::ST_IDLE;
  end

  // sequencer registers; led output only high in the pulse state
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_reg <= stereo_sync_pkg::ST_IDLE;
      cnt_reg <= CW'(0);
      alt_reg <= 1'b0;
      fired_reg <= 1'b0;
      led_reg <= 1'b0;
      color_reg <= 3'h0;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      if (vsync)
        fired_reg <= 1'b0; // RL3
      else if (light_go)
        fired_reg <= 1'b1;
      if (light_go)
        alt_reg <= !alt_reg; // RL9
      led_reg <= (st_next == stereo_sync_pkg::ST_PULSE); // RL5
      if (light_go)
        color_reg <= 3'h1 << color_sel; // RL6
    end
  end

  assign led_on = led_reg; // RL4 RL5
  assign led_color = led_reg ? color_reg : 3'h0; // RL6

  // ****************************************************************
  // helper counters for the checks
  // ****************************************************************

  // a pulse lasts thousands of cycles, far beyond what a repetition
  // can unroll, so its length is counted here and the checks read it
  logic [CW-1:0] chk_width_reg;
  logic [1:0] chk_starts_reg;
  wire logic pulse_start;

  // a pulse starts where the wait phase hands over to the pulse phase
  assign pulse_start = (st_reg == stereo_sync_pkg::ST_WAIT) &&
    (st_next == stereo_sync_pkg::ST_PULSE);

  // width counter runs while lit; start counter saturates at three so
  // that a runaway sequencer cannot wrap it back to a legal count
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      chk_width_reg <= CW'(0);
      chk_starts_reg <= 2'h0;
    end
    else
    begin
      if (led_reg)
        chk_width_reg <= chk_width_reg + CW'(1);
      else
        chk_width_reg <= CW'(0);
      // a start in the vsync cycle already belongs to the new frame
      if (vsync)
        chk_starts_reg <= pulse_start ? 2'h1 : 2'h0;
      else if (pulse_start && (chk_starts_reg != 2'h3))
        chk_starts_reg <= chk_starts_reg + 2'h1;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************

  a_led_in_pulse: assert property (@(posedge clock) disable iff (rst) // RL5
    led_on |-> $past(st_next) == stereo_sync_pkg::ST_PULSE)
    else $error("light on outside the pulse");
  a_width_lower: assert property (@(posedge clock) disable iff (rst) // RL10
    $rose(led_on) |-> led_on [*8])
    else $error("light pulse too short");
  a_light_mode: assert property (@(posedge clock) disable iff (rst) // RL3
    !light_mode |=> !led_on)
    else $error("light pulse while in infrared mode");
  a_ir_quiet: assert property (@(posedge clock) disable iff (rst) // RL2
    light_mode |-> !ir_sync)
    else $error("infrared output moved in light mode");
  a_eye_lead: assert property (@(posedge clock) disable iff (rst) // RL8
    $changed(eye_select) |-> $past(lead_hit))
    else $error("eye indicator changed away from lead point");
  a_eye_value: assert property (@(posedge clock) disable iff (rst) // RL7
    $past(lead_hit) |-> eye_select == $past(left_next))
    else $error("eye indicator wrong level");
  a_sum_exact: assert property (@(posedge clock) disable iff (rst) // RL12
    alt_c == base_c + delta_c && delta_c >= stereo_sync_pkg::DELTA_MIN_CYC)
    else $error("alternate offset not base plus delta");
  a_alternate: assert property (@(posedge clock) disable iff (rst) // RL9
    light_go ##1 1 |-> alt_reg != $past(alt_reg))
    else $error("offset did not alternate");
  a_one_pulse: assert property (@(posedge clock) disable iff (rst) // RL3
    chk_starts_reg <= 2'h1)
    else $error("second pulse in one frame");
  a_rate_gate: assert property (@(posedge clock) disable iff (rst) // RL13
    !double_rate |-> !lead_hit ##1 st_reg == stereo_sync_pkg::ST_IDLE)
    else $error("sync active without doubled rate");
  // the width bounds are counted, since a pulse spans thousands of cycles
  a_width_upper: assert property (@(posedge clock) disable iff (rst) // RL10
    led_on |-> chk_width_reg < stereo_sync_pkg::WIDTH_MAX_CYC)
    else $error("light pulse too long");
  a_width_full: assert property (@(posedge clock) disable iff (rst) // RL10
    $fell(led_on) && $past(active && light_mode) |->
      chk_width_reg >= stereo_sync_pkg::WIDTH_MIN_CYC)
    else $error("light pulse ended early");
  a_offset_floor: assert property (@(posedge clock) disable iff (rst) // RL11
    st_reg == stereo_sync_pkg::ST_IDLE && st_next == stereo_sync_pkg::ST_WAIT
      |-> cnt_next >= stereo_sync_pkg::BASE_MIN_CYC)
    else $error("pulse offset below its floor");
  a_color_onehot: assert property (@(posedge clock) disable iff (rst) // RL6
    led_on |-> $onehot0(led_color))
    else $error("more than one colour lit");
  a_led_launch: assert property (@(posedge clock) disable iff (rst) // RL4
    pulse_start |=> led_on)
    else $error("light not switched on at pulse start");
  a_ir_toggle: assert property (@(posedge clock) disable iff (rst) // RL2
    $past(lead_hit && !light_mode) && !light_mode |->
      ir_sync != $past(ir_sync))
    else $error("infrared output missed its toggle");
  a_eye_frozen: assert property (@(posedge clock) disable iff (rst) // RL13
    !active |=> $stable(eye_select))
    else $error("eye indicator moved while sync is off");

  c_pulse: cover property (@(posedge clock) disable iff (rst)
    $rose(led_on));
  c_eye_left: cover property (@(posedge clock) disable iff (rst)
    $rose(eye_select));
  c_ir_edge: cover property (@(posedge clock) disable iff (rst)
    $changed(ir_sync));
  // the second offset of the alternation, B plus D
  c_alt_pulse: cover property (@(posedge clock) disable iff (rst)
    light_go && alt_reg);
  c_eye_right: cover property (@(posedge clock) disable iff (rst)
    $fell(eye_select));

endmodule
`default_nettype wire

// ==== stereo_shutter_sync_bench.sv ====
// testbench for the stereo shutter sync block
`timescale 1ns/1ps
`default_nettype none
module stereo_shutter_sync_bench;
  logic clock, rst, stereo_en, light_mode, double_rate, vsync, subframe_end;
  logic left_next, eye_select, ir_sync, led_on;
  logic [1:0] color_sel;
  logic [2:0] led_color;
  logic [7:0] pulse_count;
  logic [23:0] base_cfg, delta_cfg, width_cfg, width_seen;
  int miscompares = 0;
  int total_checks = 0;

  stereo_shutter_sync stereo_shutter_sync_inst (.clock(clock), .rst(rst),
    .stereo_en(stereo_en), .light_mode(light_mode),
    .double_rate(double_rate), .color_sel(color_sel), .base_cfg(base_cfg),
    .delta_cfg(delta_cfg), .width_cfg(width_cfg), .vsync(vsync),
    .subframe_end(subframe_end), .left_next(left_next),
    .eye_select(eye_select), .ir_sync(ir_sync), .led_on(led_on),
    .led_color(led_color));
  glasses_model glasses_model_inst (.clock(clock), .rst(rst),
    .led_on(led_on), .led_color(led_color), .pulse_count(pulse_count),
    .width_seen(width_seen));

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic check(input string name, input logic [23:0] seen,
    input logic [23:0] exp);
  begin
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  end
  endtask

  task automatic stop_test;
  begin
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset;
  begin
    check("eye_select", {23'h0, eye_select}, 24'h000001);
    check("ir_sync", {23'h0, ir_sync}, 24'h000000);
    check("led_on", {23'h0, led_on}, 24'h000000);
    check("led_color", {21'h0, led_color}, 24'h000000);
    $display("test_reset done");
  end
  endtask

  // settings below the limits must be pulled up to them; a second
  // subframe end in the same frame must not give a second pulse
  task automatic test_pulse;
    int n;
  begin
    n = 0;
    @(posedge clock);
    vsync <= 1'b1;
    @(posedge clock);
    vsync <= 1'b0;
    subframe_end <= 1'b1;
    @(posedge clock);
    subframe_end <= 1'b0;
    #1;
    while (led_on !== 1'b1 && n < 130000)
    begin
      @(posedge clock);
      subframe_end <= (n == 999);
      n++;
      #1;
    end
    check("offset_ok", {23'h0, n >= 125001 && n <= 125002}, 24'h000001);
    check("led_color_red", {21'h0, led_color}, 24'h000001);
    check("ir_gated", {23'h0, ir_sync}, 24'h000000);
    repeat (5100) @(posedge clock);
    #1;
    check("led_off", {23'h0, led_on}, 24'h000000);
    check("color_off", {21'h0, led_color}, 24'h000000);
    check("width", width_seen, 24'h001388);
    check("pulses", {16'h0, pulse_count}, 24'h000001);
    $display("test_pulse done");
  end
  endtask

  // infrared mode: a short frame puts the lead just after vsync, where
  // the eye takes the right-eye level and the IR output toggles
  task automatic test_infrared;
    logic prev;
  begin
    @(posedge clock);
    light_mode <= 1'b0;
    left_next <= 1'b0;
    vsync <= 1'b1;
    @(posedge clock);
    vsync <= 1'b0;
    #1;
    prev = ir_sync;
    @(posedge clock);
    #1;
    check("eye_right", {23'h0, eye_select}, 24'h000000);
    check("ir_toggle", {23'h0, ir_sync}, {23'h0, !prev});
    check("led_quiet", {23'h0, led_on}, 24'h000000);
    $display("test_infrared done");
  end
  endtask

  // ****************************************
  // clock, reset, sequence and watchdog
  // ****************************************
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial
  begin
    rst = 1'b1;
    stereo_en = 1'b1;
    light_mode = 1'b1;
    double_rate = 1'b1;
    color_sel = 2'h0;
    base_cfg = 24'h000010;
    delta_cfg = 24'h007D00;
    width_cfg = 24'h000000;
    vsync = 1'b0;
    subframe_end = 1'b0;
    left_next = 1'b1;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    test_reset();
    test_pulse();
    test_infrared();
    stop_test();
  end

  // one pulse takes about 130000 cycles; over twice that means a hang
  initial
  begin
    repeat (300000) @(posedge clock);
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire

// ==== stereo_sync_pkg.sv ====
// constants and types shared by the stereo shutter sync block
//
// Summary of operation
// [RL1] in stereo mode, emit sync aligning glasses shutters with mirror frames
// [RL2] infrared mode drives a dedicated output that toggles the IR transmitter
// [RL3] light mode emits exactly one light pulse per frame, shutters closed
// [RL4] illumination driver is told when to switch the source on each frame
// [RL5] source stays off while shutters closed, except during the pulse
// [RL6] pulse colour is selectable; red recommended, blue to be avoided
// [RL7] eye indicator is one for left frame, zero for right frame
// [RL8] eye indicator changes one millisecond before the frame's vsync
// [RL9] pulse offset from subframe end alternates between B and B plus D
// [RL10] light pulse width stays between 20 and 32 microseconds
// [RL11] B above 500 us, D 128 to 163 us, E above 2000 us; GAP_MIN_CYC is defined but nothing enforces E
// [RL12] alternate offset C equals B plus D exactly
// [RL13] this timing applies when input rate is twice the source rate
// [RL14] timings come from clock counters referenced to vsync, settings held
package stereo_sync_pkg;

  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned CW = 24;

  // times in their own units, cycle counts derived from the clock rate
  localparam int unsigned LEAD_US = 1000;
  localparam int unsigned WIDTH_MIN_US = 20;
  localparam int unsigned WIDTH_MAX_US = 32;
  localparam int unsigned BASE_MIN_US = 500;
  localparam int unsigned DELTA_MIN_US = 128;
  localparam int unsigned DELTA_MAX_US = 163;
  localparam int unsigned GAP_MIN_US = 2000;

  localparam logic [CW-1:0] LEAD_CYC = CW'(LEAD_US * CLK_MHZ);
  localparam logic [CW-1:0] WIDTH_MIN_CYC = CW'(WIDTH_MIN_US * CLK_MHZ);
  localparam logic [CW-1:0] WIDTH_MAX_CYC = CW'(WIDTH_MAX_US * CLK_MHZ);
  localparam logic [CW-1:0] BASE_MIN_CYC = CW'(BASE_MIN_US * CLK_MHZ + 1);
  localparam logic [CW-1:0] DELTA_MIN_CYC = CW'(DELTA_MIN_US * CLK_MHZ);
  localparam logic [CW-1:0] DELTA_MAX_CYC = CW'(DELTA_MAX_US * CLK_MHZ);
  localparam logic [CW-1:0] GAP_MIN_CYC = CW'(GAP_MIN_US * CLK_MHZ + 1);

  // nominal 60 Hz source defaults: width 26.0 us, delta 132.0 us
  localparam logic [CW-1:0] WIDTH_RST = CW'(26 * CLK_MHZ);
  localparam logic [CW-1:0] BASE_RST = CW'(520 * CLK_MHZ);
  localparam logic [CW-1:0] DELTA_RST = CW'(132 * CLK_MHZ);

  // colour selection
  localparam logic [1:0] COLOR_RED = 2'h0;
  localparam logic [1:0] COLOR_GREEN = 2'h1;
  localparam logic [1:0] COLOR_BLUE = 2'h2;

  // light pulse sequencer, gray coded from idle through wait to pulse; the return to idle flips both bits
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_PULSE = 2'b11
  } pulse_state_t;

endpackage
